// *** design/wlhs_pkg.sv ***
// Package for the wake, level and high-side status register group.
// Assumes a 7-bit register address from the SPI frame decoder and 8-bit data.
package wlhs_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_WAKE_SOURCE_FLAGS_A    = 7'h46;  // Bus, timer, HV input wake flags
  localparam logic [6:0] ADDR_WAKE_SOURCE_FLAGS_B    = 7'h47;  // GPIO wake flags
  localparam logic [6:0] ADDR_INPUT_LEVEL_STATUS     = 7'h48;  // Pin levels and straps
  localparam logic [6:0] ADDR_SWITCH_OVERLOAD_FLAGS  = 7'h54;  // High-side OC/OT flags
  localparam logic [6:0] ADDR_SWITCH_OPEN_LOAD_FLAGS = 7'h55;  // High-side open-load flags

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LIN_BUS_WAKE_FLAG_POS      = 6;
  localparam int CAN_BUS_WAKE_FLAG_POS      = 5;
  localparam int CYCLIC_TIMER_WAKE_FLAG_POS = 4;
  localparam int HV_INPUT_WAKE_FLAG_LSB     = 0;  // Inputs one to three at bits 0..2
  localparam int IO_WAKE_FLAG_LSB           = 4;  // GPIO1 at 4, GPIO2 at 5
  localparam int DEVELOPMENT_MODE_STRAP_POS = 7;
  localparam int INTERRUPT_PULLUP_STRAP_POS = 6;
  localparam int IO_LEVEL_LSB               = 4;
  localparam int HV_INPUT_LEVEL_LSB         = 0;
  localparam int SWITCH_FLAG_LSB            = 0;  // Switches one to four at bits 0..3

  // ----------------------------------------------------------------------
  // Writable bit masks (all other bits are reserved and read as zero)
  // ----------------------------------------------------------------------
  localparam logic [7:0] MASK_WAKE_SOURCE_FLAGS_A = 8'h77;
  localparam logic [7:0] MASK_WAKE_SOURCE_FLAGS_B = 8'h30;
  localparam logic [7:0] MASK_INPUT_LEVEL_STATUS  = 8'hf7;
  localparam logic [7:0] MASK_SWITCH_FLAGS        = 8'h0f;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_FLAGS      = 8'h00;  // All clear-on-read registers
  localparam logic [7:0] RESET_READ_DATA  = 8'h00;
  localparam logic [2:0] RESET_HV_LEVELS  = 3'h0;
  localparam logic [1:0] RESET_IO_LEVELS  = 2'h0;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  // Wake events, one-cycle pulses from the wake detectors
  typedef struct packed {
    logic       lin;    // LIN bus wake
    logic       can;    // CAN bus wake
    logic       timer;  // Cyclic wake timer expiry
    logic [2:0] hv;     // HV wake inputs three..one
    logic [1:0] io;     // GPIO two..one
  } wlhs_wake_evt_t;

  // Per-GPIO configuration as seen by the level logic
  typedef struct packed {
    logic selected;     // Pin is selected for GPIO use
    logic active_cfg;   // Configured as wake input, low-side or high-side switch
  } wlhs_io_cfg_t;

endpackage : wlhs_pkg

// *** design/wlhs_flag_bank.sv ***
// Bank of sticky clear-on-read flags.
// Assumes set pulses and the clear strobe are synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none

module wlhs_flag_bank
  import wlhs_pkg::*;
#(
  parameter int W = 8  // Flag count
) (
  input  wire logic         mclk_i,   // System clock
  input  wire logic         srst_i,   // Power-on or soft reset
  input  wire logic [W-1:0] set_i,    // Set requests, already masked
  input  wire logic         clr_i,    // Clearing read of this register
  output logic      [W-1:0] flags_o   // Latched flags
);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (W < 1 || W > 8) begin : g_bad_width
    $error("wlhs_flag_bank: W must be 1 to 8");
  end

  // ----------------------------------------------------------------------
  // Flag storage
  // ----------------------------------------------------------------------
  // Only reset and a clearing read drop a flag; a set in the same cycle wins
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flags_o <= RESET_FLAGS[W-1:0];
    end else begin
      flags_o <= (flags_o & ~{W{clr_i}}) | set_i;
    end
  end

endmodule : wlhs_flag_bank
`default_nettype wire

// *** design/wlhs_level_sampler.sv ***
// Level tracking for the HV wake inputs and the two GPIO pins.
// Assumes pins are already synchronous and sample_i marks each cyclic sample.
`timescale 1ns/1ps
`default_nettype none

module wlhs_level_sampler
  import wlhs_pkg::*;
(
  input  wire logic         mclk_i,         // System clock
  input  wire logic         srst_i,         // Power-on or soft reset
  input  wire logic [2:0]   hv_pin_i,       // HV wake input pins three..one
  input  wire logic [2:0]   hv_cyclic_i,    // Input under cyclic sensing
  input  wire logic         sample_i,       // Cyclic sampling instant
  input  wire logic [1:0]   io_pin_i,       // GPIO pins two..one
  input  wire wlhs_io_cfg_t io_cfg_i [2],   // GPIO configuration
  input  wire logic         run_mode_i,     // Normal or stop mode
  output logic      [2:0]   hv_level_o,     // Reported HV levels
  output logic      [1:0]   io_level_o      // Reported GPIO levels
);

  // ----------------------------------------------------------------------
  // HV input levels
  // ----------------------------------------------------------------------
  // Continuous inputs follow the pin; cyclic ones load only at a sample
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      hv_level_o <= RESET_HV_LEVELS;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!hv_cyclic_i[i] || sample_i) begin
          hv_level_o[i] <= hv_pin_i[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // GPIO levels
  // ----------------------------------------------------------------------
  // No cyclic sensing here: the sample strobe is deliberately ignored
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      io_level_o <= RESET_IO_LEVELS;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (run_mode_i && io_cfg_i[i].selected && io_cfg_i[i].active_cfg) begin
          io_level_o[i] <= io_pin_i[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  hv_cyclic_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (hv_cyclic_i[0] && !sample_i) |=> $stable(hv_level_o[0]))
    else $error("cyclic HV level changed without a sample");

  io_level_track_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (run_mode_i && io_cfg_i[0].selected && io_cfg_i[0].active_cfg) |=> io_level_o[0] == $past(io_pin_i[0]))
    else $error("GPIO1 level not tracking its pin");

  io_no_sample_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (sample_i && !(run_mode_i && io_cfg_i[1].selected)) |=> $stable(io_level_o[1]))
    else $error("GPIO2 level loaded by a cyclic sample");

endmodule : wlhs_level_sampler
`default_nettype wire

// *** design/wlhs_status_regs.sv ***
// Wake, input level and high-side switch status registers.
// Assumes the SPI frame decoder gives a one-cycle read strobe with address
// and a clear flag; pins, straps and events are synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none

module wlhs_status_regs
  import wlhs_pkg::*;
(
  input  wire logic           mclk_i,             // System clock, 100 MHz
  input  wire logic           srst_i,             // Power-on or soft reset
  // Register port from the SPI frame decoder
  input  wire logic           rd_en_i,            // Read strobe
  input  wire logic [6:0]     rd_addr_i,          // Register address
  input  wire logic           rd_clr_i,           // Read also clears the flags
  output logic      [7:0]     rd_data_o,          // Read data
  output logic                rd_valid_o,         // Read data valid
  // Events
  input  wire wlhs_wake_evt_t wake_evt_i,         // Wake events
  input  wire wlhs_wake_evt_t failsafe_src_i,     // Source of a wake out of fail-safe
  input  wire logic [3:0]     overload_i,         // OC/OT event per switch
  input  wire logic [3:0]     open_load_i,        // Open-load event per switch
  // Levels and straps
  input  wire logic [2:0]     hv_pin_i,           // HV wake input pins
  input  wire logic [2:0]     hv_cyclic_i,        // Cyclic sensing per input
  input  wire logic           sample_i,           // Cyclic sampling instant
  input  wire logic [1:0]     io_pin_i,           // GPIO pins
  input  wire wlhs_io_cfg_t   io_cfg_i [2],       // GPIO configuration
  input  wire logic           run_mode_i,         // Normal or stop mode
  input  wire logic           dev_strap_pin_i,    // Test pin operating-mode strap
  input  wire logic           pullup_strap_pin_i, // Pull-up sensed on interrupt pin
  // Transceiver
  input  wire logic           trx_mode_bit_i,     // Transceiver mode control bit
  output logic                uv_cmp_en_o         // Supply undervoltage comparator enable
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  wlhs_wake_evt_t wake_any;                     // Normal and fail-safe wake sources
  logic [7:0]     set_wake_a;                   // Set vector, register A
  logic [7:0]     set_wake_b;                   // Set vector, register B
  logic [7:0]     set_overload;                 // Set vector, overload
  logic [7:0]     set_open_load;                // Set vector, open load
  logic           clr_wake_a;                   // Clearing read strobes
  logic           clr_wake_b;
  logic           clr_overload;
  logic           clr_open_load;
  logic [7:0]     wake_source_flags_a;          // Register contents
  logic [7:0]     wake_source_flags_b;
  logic [7:0]     switch_overload_flags;
  logic [7:0]     switch_open_load_flags;
  logic [7:0]     input_level_status;
  logic [2:0]     hv_level;                     // Sampler outputs
  logic [1:0]     io_level;
  logic           development_mode_strap;       // Captured straps
  logic           interrupt_pullup_strap;
  logic           strap_done;                   // Straps captured since reset
  logic [7:0]     next_rd_data;                 // Read multiplexer

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // True when a clearing read targets the given address
  function automatic logic clr_hit(input logic [6:0] addr);
    return rd_en_i && rd_clr_i && (rd_addr_i == addr);
  endfunction

  // Strobes for each clear-on-read register
  always_comb begin
    clr_wake_a    = clr_hit(ADDR_WAKE_SOURCE_FLAGS_A);
    clr_wake_b    = clr_hit(ADDR_WAKE_SOURCE_FLAGS_B);
    clr_overload  = clr_hit(ADDR_SWITCH_OVERLOAD_FLAGS);
    clr_open_load = clr_hit(ADDR_SWITCH_OPEN_LOAD_FLAGS);
  end

  // ----------------------------------------------------------------------
  // Set vectors
  // ----------------------------------------------------------------------
  // Wake out of fail-safe sets the same flag as an ordinary wake
  always_comb begin
    wake_any = wake_evt_i | failsafe_src_i;
    set_wake_a = 8'h00;
    set_wake_a[LIN_BUS_WAKE_FLAG_POS]      = wake_any.lin;
    set_wake_a[CAN_BUS_WAKE_FLAG_POS]      = wake_any.can;
    set_wake_a[CYCLIC_TIMER_WAKE_FLAG_POS] = wake_any.timer;
    set_wake_a[HV_INPUT_WAKE_FLAG_LSB +: 3] = wake_any.hv;
    set_wake_a = set_wake_a & MASK_WAKE_SOURCE_FLAGS_A;
    set_wake_b = 8'h00;
    set_wake_b[IO_WAKE_FLAG_LSB +: 2] = wake_any.io;
    set_wake_b = set_wake_b & MASK_WAKE_SOURCE_FLAGS_B;
    set_overload = 8'h00;
    set_overload[SWITCH_FLAG_LSB +: 4] = overload_i;
    set_open_load = 8'h00;
    set_open_load[SWITCH_FLAG_LSB +: 4] = open_load_i;
  end

  // ----------------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------------
  // Restart is not an input: only srst_i and a clearing read clear, so restart keeps the flags
  wlhs_flag_bank #(.W(8)) u_wake_a (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .set_i   (set_wake_a),
    .clr_i   (clr_wake_a),
    .flags_o (wake_source_flags_a)
  );

  wlhs_flag_bank #(.W(8)) u_wake_b (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .set_i   (set_wake_b),
    .clr_i   (clr_wake_b),
    .flags_o (wake_source_flags_b)
  );

  wlhs_flag_bank #(.W(8)) u_overload (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .set_i   (set_overload),
    .clr_i   (clr_overload),
    .flags_o (switch_overload_flags)
  );

  wlhs_flag_bank #(.W(8)) u_open_load (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .set_i   (set_open_load),
    .clr_i   (clr_open_load),
    .flags_o (switch_open_load_flags)
  );

  // ----------------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------------
  wlhs_level_sampler u_levels (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .hv_pin_i    (hv_pin_i),
    .hv_cyclic_i (hv_cyclic_i),
    .sample_i    (sample_i),
    .io_pin_i    (io_pin_i),
    .io_cfg_i    (io_cfg_i),
    .run_mode_i  (run_mode_i),
    .hv_level_o  (hv_level),
    .io_level_o  (io_level)
  );

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  // Straps are caught once, on the first edge after reset release
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      strap_done             <= 1'b0;
      development_mode_strap <= 1'b0;
      interrupt_pullup_strap <= 1'b0;
    end else if (!strap_done) begin
      strap_done             <= 1'b1;
      development_mode_strap <= dev_strap_pin_i;
      interrupt_pullup_strap <= pullup_strap_pin_i;
    end
  end

  // Level register assembly, reserved bit 3 forced low
  always_comb begin
    input_level_status = 8'h00;
    input_level_status[DEVELOPMENT_MODE_STRAP_POS] = development_mode_strap;
    input_level_status[INTERRUPT_PULLUP_STRAP_POS] = interrupt_pullup_strap;
    input_level_status[IO_LEVEL_LSB +: 2]          = io_level;
    input_level_status[HV_INPUT_LEVEL_LSB +: 3]    = hv_level;
    input_level_status = input_level_status & MASK_INPUT_LEVEL_STATUS;
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Unmapped addresses read as zero
  always_comb begin
    case (rd_addr_i)
      ADDR_WAKE_SOURCE_FLAGS_A:    next_rd_data = wake_source_flags_a;
      ADDR_WAKE_SOURCE_FLAGS_B:    next_rd_data = wake_source_flags_b;
      ADDR_INPUT_LEVEL_STATUS:     next_rd_data = input_level_status;
      ADDR_SWITCH_OVERLOAD_FLAGS:  next_rd_data = switch_overload_flags & MASK_SWITCH_FLAGS;
      ADDR_SWITCH_OPEN_LOAD_FLAGS: next_rd_data = switch_open_load_flags & MASK_SWITCH_FLAGS;
      default:                     next_rd_data = 8'h00;
    endcase
  end

  // Data is the value before any clear of the same read
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rd_data_o  <= RESET_READ_DATA;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) begin
        rd_data_o <= next_rd_data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transceiver undervoltage comparator
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      uv_cmp_en_o <= 1'b0;
    end else begin
      uv_cmp_en_o <= trx_mode_bit_i;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  uv_enable_follow_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    ##1 uv_cmp_en_o == $past(trx_mode_bit_i))
    else $error("comparator enable does not follow the mode bit");

  lin_wake_set_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wake_evt_i.lin |=> wake_source_flags_a[6])
    else $error("LIN wake did not set bit 6");

  failsafe_wake_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    failsafe_src_i.hv[2] |=> wake_source_flags_a[2])
    else $error("fail-safe wake did not set its source flag");

  reserved_zero_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    rd_valid_o && $past(rd_addr_i) == ADDR_WAKE_SOURCE_FLAGS_B |-> rd_data_o[7:6] == 2'h0 && rd_data_o[3:0] == 4'h0)
    else $error("reserved bits read as one");

  io_wake_set_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wake_evt_i.io[1] |=> wake_source_flags_b[5])
    else $error("GPIO2 wake did not set bit 5");

  strap_capture_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!srst_i && !strap_done) |=> input_level_status[7] == $past(dev_strap_pin_i) &&
      input_level_status[6] == $past(pullup_strap_pin_i))
    else $error("strap bits not captured after reset");

  overload_set_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    overload_i[3] |=> switch_overload_flags[3])
    else $error("overload did not set its flag");

  open_load_set_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    open_load_i[0] |=> switch_open_load_flags[0])
    else $error("open load did not set its flag");

  flag_sticky_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (switch_open_load_flags[1] && !clr_open_load) |=>
      switch_open_load_flags[1] ##1 (switch_open_load_flags[1] || $past(clr_open_load)))
    else $error("flag dropped without a clearing read");

  set_wins_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (clr_open_load && open_load_i[1]) |=> switch_open_load_flags[1])
    else $error("event lost during clearing read");

  read_answer_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    rd_en_i |=> rd_valid_o)
    else $error("read strobe got no data valid cycle");

  read_overload_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_en_i && rd_addr_i == ADDR_SWITCH_OVERLOAD_FLAGS) |=>
      rd_data_o == ($past(switch_overload_flags) & MASK_SWITCH_FLAGS))
    else $error("overload read data differs from the flags");

  open_load_clear_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (clr_open_load && open_load_i == 4'h0) |=> switch_open_load_flags == 8'h00)
    else $error("clearing read left an open-load flag set");

  overload_clear_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (clr_overload && overload_i == 4'h0) |=> switch_overload_flags == 8'h00)
    else $error("clearing read left an overload flag set");

  hv_level_follow_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!srst_i && !hv_cyclic_i[1]) |=> hv_level[1] == $past(hv_pin_i[1]))
    else $error("continuous HV level not following its pin");

  strap_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    strap_done |=> $stable(development_mode_strap))
    else $error("strap changed after capture");

  io_one_wake_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wake_evt_i.io[0] |=> wake_source_flags_b[4])
    else $error("GPIO1 wake did not set bit 4");

endmodule : wlhs_status_regs
`default_nettype wire

// *** sim/wlhs_host_model.sv ***
// Host model: reads status registers through the frame decoder port.
// Assumes a one-cycle read strobe and read data valid one cycle after it.
`timescale 1ns/1ps
`default_nettype none

module wlhs_host_model (
  input  wire logic       mclk_i,     // System clock
  output logic            rd_en_o,    // Read strobe
  output logic      [6:0] rd_addr_o,  // Register address
  output logic            rd_clr_o,   // Clearing read
  input  wire logic [7:0] rd_data_i,  // Read data
  input  wire logic       rd_valid_i  // Read data valid
);
  // ----------------------------------------------------------------------
  // Idle port at time zero
  // ----------------------------------------------------------------------
  initial begin
    rd_en_o   = 1'b0;
    rd_addr_o = 7'h00;
    rd_clr_o  = 1'b0;
  end

  // One read; flags go only when the host asks for a clearing read
  task automatic read(input logic [6:0] a, input logic c, output logic [7:0] d);
    d = 8'hxx;
    @(posedge mclk_i);
    rd_en_o   <= 1'b1;
    rd_addr_o <= a;
    rd_clr_o  <= c;
    @(posedge mclk_i);
    rd_en_o   <= 1'b0;
    rd_addr_o <= ~a;  // Stale address scrambled once the strobe drops
    rd_clr_o  <= ~c;  // Clear without strobe must be ignored
    @(posedge mclk_i);
    // Data is due exactly one cycle after the strobe; late data stays unknown
    if (rd_valid_i === 1'b1) begin
      d = rd_data_i;
    end
  endtask
endmodule // wlhs_host_model

`default_nettype wire

// *** sim/tb_top.sv ***
// Testbench for the wake, level and high-side status registers.
// Assumes the host model sits on the read port; all else driven here.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import wlhs_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic           mclk_i, srst_i, sample_i, run_mode_i, dev, pup, trx;
  logic           rd_en, rd_clr, rd_valid, uv;
  logic     [6:0] rd_addr;
  logic     [7:0] rd_data, d;
  wlhs_wake_evt_t wake_evt, fs_src;
  logic     [3:0] ov, ol;
  logic     [2:0] hv_pin, hv_cyc;
  logic     [1:0] io_pin;
  wlhs_io_cfg_t   io_cfg [2];
  int             n_mismatch, num_checks;

  wlhs_status_regs dut (.mclk_i(mclk_i), .srst_i(srst_i), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
    .rd_clr_i(rd_clr), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .wake_evt_i(wake_evt),
    .failsafe_src_i(fs_src), .overload_i(ov), .open_load_i(ol), .hv_pin_i(hv_pin),
    .hv_cyclic_i(hv_cyc), .sample_i(sample_i), .io_pin_i(io_pin), .io_cfg_i(io_cfg),
    .run_mode_i(run_mode_i), .dev_strap_pin_i(dev), .pullup_strap_pin_i(pup),
    .trx_mode_bit_i(trx), .uv_cmp_en_o(uv));
  wlhs_host_model host (.mclk_i(mclk_i), .rd_en_o(rd_en), .rd_addr_o(rd_addr), .rd_clr_o(rd_clr),
    .rd_data_i(rd_data), .rd_valid_i(rd_valid));

  // ----------------------------------------------------------------------
  // Clock, verdict and watchdog
  // ----------------------------------------------------------------------
  always #5 mclk_i = ~mclk_i;

  // Counts, verdict, end of run
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read one register and compare
  task automatic rd(input logic [6:0] a, input logic c, input logic [7:0] exp);
    logic [7:0] v;
    host.read(a, c, v);
    check8(v, exp);
  endtask

  // One-cycle pulse on the event inputs
  task automatic pulse(input logic [7:0] w, input logic [7:0] f, input logic [3:0] o, input logic [3:0] l);
    @(posedge mclk_i);
    wake_evt <= wlhs_wake_evt_t'(w);
    fs_src   <= wlhs_wake_evt_t'(f);
    ov       <= o;
    ol       <= l;
    @(posedge mclk_i);
    wake_evt <= '0;
    fs_src   <= '0;
    ov       <= 4'h0;
    ol       <= 4'h0;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    mclk_i = 1'b0; srst_i = 1'b1; sample_i = 1'b0; run_mode_i = 1'b1; dev = 1'b1; pup = 1'b0;
    trx = 1'b0; wake_evt = '0; fs_src = '0; ov = 4'h0; ol = 4'h0; hv_pin = 3'h0; hv_cyc = 3'h0;
    io_pin = 2'h0; io_cfg[0] = 2'h3; io_cfg[1] = 2'h2; n_mismatch = 0; num_checks = 0;
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rd(7'h46, 1'b1, 8'h00);
    rd(7'h47, 1'b1, 8'h00);
    rd(7'h54, 1'b1, 8'h00);
    rd(7'h55, 1'b1, 8'h00);
    rd(7'h48, 1'b0, 8'h80);
    pulse(8'hff, 8'h00, 4'h0, 4'h0);
    rd(7'h50, 1'b1, 8'h00);
    rd(7'h46, 1'b0, 8'h77);
    rd(7'h46, 1'b1, 8'h77);
    rd(7'h46, 1'b0, 8'h00);
    rd(7'h47, 1'b1, 8'h30);
    pulse(8'h00, 8'h81, 4'h0, 4'h0);
    rd(7'h46, 1'b1, 8'h40);
    rd(7'h47, 1'b1, 8'h10);
    for (int i = 0; i < 4; i++) begin
      pulse(8'h00, 8'h00, 4'h1 << i, 4'h8 >> i);
      rd(7'h54, 1'b1, 8'h01 << i);
      rd(7'h55, 1'b1, 8'h08 >> i);
    end
    // Open-load event lands in the same cycle as its clearing read
    fork
      host.read(7'h55, 1'b1, d);
      pulse(8'h00, 8'h00, 4'h0, 4'h2);
    join
    check8(d, 8'h00);
    rd(7'h55, 1'b1, 8'h02);
    hv_pin <= 3'h5;
    io_pin <= 2'h3;
    repeat (2) @(posedge mclk_i);
    rd(7'h48, 1'b0, 8'h95);
    hv_cyc <= 3'h7;
    hv_pin <= 3'h2;
    run_mode_i <= 1'b0;
    io_pin <= 2'h0;
    repeat (3) @(posedge mclk_i);
    rd(7'h48, 1'b1, 8'h95);
    @(posedge mclk_i) sample_i <= 1'b1;
    @(posedge mclk_i) sample_i <= 1'b0;
    rd(7'h48, 1'b0, 8'h92);
    trx <= 1'b1;
    repeat (2) @(posedge mclk_i);
    check8({7'h00, uv}, 8'h01);
    trx <= 1'b0;
    repeat (2) @(posedge mclk_i);
    check8({7'h00, uv}, 8'h00);
    pulse(8'hff, 8'h00, 4'hf, 4'hf);
    srst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    dev <= 1'b0;
    pup <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rd(7'h46, 1'b0, 8'h00);
    rd(7'h54, 1'b0, 8'h00);
    rd(7'h48, 1'b0, 8'h40);
    print_verdict();
  end
endmodule // tb_top

`default_nettype wire
